// File: inc/dito_regs.vh
// register offsets, field positions, reset values and timing counts of the timing optimizer
`ifndef DITO_REGS_VH
`define DITO_REGS_VH

// register port widths and data pin port width
`define DITO_ADDR_W 6
`define DITO_DATA_W 8
`define DITO_PORT_W 16

// register offsets
`define DITO_OFS_MODE 6'h03
`define DITO_OFS_DELAY 6'h04
`define DITO_OFS_MARGIN 6'h05
`define DITO_OFS_REFSEL 6'h06
`define DITO_OFS_IRQEN 6'h07
`define DITO_OFS_STATUS 6'h19

// field positions
`define DITO_MODE_AUTO_BIT 7
`define DITO_DELAY_EN_BIT 7
`define DITO_DELAY_CODE_MSB 4
`define DITO_MARGIN_MSB 3
`define DITO_REFSEL_BIT 0
`define DITO_IRQEN_BIT 0
`define DITO_STAT_ERR_BIT 0
`define DITO_STAT_TYPE_BIT 1
`define DITO_STAT_SYNC_BIT 2
`define DITO_STAT_PEND_BIT 3

// reset values
`define DITO_RST_AUTO 1'b0
`define DITO_RST_DELAY_EN 1'b0
`define DITO_RST_CODE 5'h00
`define DITO_RST_MARGIN 4'h0
`define DITO_RST_REFSEL 1'b0
`define DITO_RST_IRQEN 1'b0

// delay code limits
`define DITO_CODE_MIN 5'h00
`define DITO_CODE_MAX 5'h1F

// timing: link word period in ns and clock period in ns
`define DITO_WORD_PERIOD_NS 48
`define DITO_CLOCK_PERIOD_NS 4
`define DITO_WORD_CYCLES (`DITO_WORD_PERIOD_NS / `DITO_CLOCK_PERIOD_NS)
`define DITO_PHASE_W 4
// last phase of a word period and the phase at which the base clock falls
`define DITO_LAST_PHASE 4'hB
`define DITO_HALF_PHASE 4'h6
// captures skipped after an automatic step so the new delay can settle
`define DITO_SETTLE_CAPTURES 4'h4

// capture history: real capture tap sits in the middle
`define DITO_HIST_DEPTH 32
`define DITO_REAL_TAP 16

`endif

// File: hdl/dito_top.v
// data input timing optimizer: margin captures, error flagging and forwarded clock delay
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "dito_regs.vh"

module dito_top (
    input wire clock,
    input wire reset_n,
    input wire [`DITO_ADDR_W-1:0] reg_addr,
    input wire [`DITO_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`DITO_DATA_W-1:0] reg_rdata,
    input wire [`DITO_PORT_W-1:0] data_pin,
    input wire sync_pin,
    output reg forwarded_data_clock,
    output reg [`DITO_PORT_W-1:0] captured_data,
    output reg captured_valid,
    output reg sync_sampled,
    output reg irq_n_out,
    output reg irq_n_oe
);

    localparam [`DITO_PHASE_W-1:0] LAST_PHASE = `DITO_LAST_PHASE;
    localparam [`DITO_PHASE_W-1:0] HALF_PHASE = `DITO_HALF_PHASE;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers

    reg auto_mode;
    reg delay_line_enable;
    reg [`DITO_DELAY_CODE_MSB:0] clock_delay_code;
    reg [`DITO_MARGIN_MSB:0] margin;
    reg timed_to_reference;
    reg irq_enable;
    reg err_flag;
    reg err_type;
    reg check_pending;
    reg [3:0] settle;

    wire wr_mode = reg_wr && (reg_addr == `DITO_OFS_MODE);
    wire wr_delay = reg_wr && (reg_addr == `DITO_OFS_DELAY);
    wire wr_margin = reg_wr && (reg_addr == `DITO_OFS_MARGIN);
    wire wr_refsel = reg_wr && (reg_addr == `DITO_OFS_REFSEL);
    wire wr_irqen = reg_wr && (reg_addr == `DITO_OFS_IRQEN);
    wire wr_status = reg_wr && (reg_addr == `DITO_OFS_STATUS);

    wire [`DITO_DELAY_CODE_MSB:0] wr_code = reg_wdata[`DITO_DELAY_CODE_MSB:0];
    wire [`DITO_MARGIN_MSB:0] wr_margin_val = reg_wdata[`DITO_MARGIN_MSB:0];

    // manual entry is an auto-to-manual transition
    wire enter_manual = wr_mode && auto_mode && !reg_wdata[`DITO_MODE_AUTO_BIT];
    wire cfg_changed = (wr_delay && (wr_code != clock_delay_code)) ||
                       (wr_margin && (wr_margin_val != margin));

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    reg [`DITO_PORT_W-1:0] data_meta;
    reg [`DITO_PORT_W-1:0] data_sync;
    reg sync_meta;

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_meta <= 16'h0000;
            data_sync <= 16'h0000;
            sync_meta <= 1'b0;
            sync_sampled <= 1'b0;
        end else begin
            data_meta <= data_pin;
            data_sync <= data_meta;
            sync_meta <= sync_pin;
            sync_sampled <= sync_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // word rate divider and forwarded clock delay line

    reg [`DITO_PHASE_W-1:0] phase;
    reg base_clock;
    reg [`DITO_HIST_DEPTH-1:0] delay_line;
    wire capture_strobe = (phase == 4'h0);

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 4'h0;
            base_clock <= 1'b0;
        end else begin
            if (phase == LAST_PHASE) begin
                phase <= 4'h0;
            end else begin
                phase <= phase + 4'h1;
            end
            base_clock <= (phase < HALF_PHASE);
        end
    end

    // one delay step is one clock cycle here; the analog line has finer steps
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            delay_line <= 32'h00000000;
            forwarded_data_clock <= 1'b0;
        end else begin
            delay_line <= {delay_line[`DITO_HIST_DEPTH-2:0], base_clock};
            if (delay_line_enable) begin
                forwarded_data_clock <= delay_line[clock_delay_code];
            end else begin
                forwarded_data_clock <= base_clock;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // capture history and margin captures

    reg [`DITO_PORT_W-1:0] hist [0:`DITO_HIST_DEPTH-1];
    integer i;

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < `DITO_HIST_DEPTH; i = i + 1) begin
                hist[i] <= 16'h0000;
            end
        end else begin
            hist[0] <= data_sync;
            for (i = 1; i < `DITO_HIST_DEPTH; i = i + 1) begin
                hist[i] <= hist[i-1];
            end
        end
    end

    // older samples stand for earlier sampling instants
    wire [4:0] early_tap = 5'h10 + {1'b0, margin};
    wire [4:0] late_tap = 5'h10 - {1'b0, margin};
    wire [`DITO_PORT_W-1:0] real_word = hist[`DITO_REAL_TAP];
    wire [`DITO_PORT_W-1:0] early_word = hist[early_tap];
    wire [`DITO_PORT_W-1:0] late_word = hist[late_tap];
    wire setup_miss = (early_word != real_word);
    wire hold_miss = (late_word != real_word);

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            captured_data <= 16'h0000;
            captured_valid <= 1'b0;
        end else begin
            captured_valid <= capture_strobe;
            if (capture_strobe) begin
                captured_data <= real_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // error check and automatic tuning

    // no checking while data is timed against the reference clock
    wire check_now = capture_strobe && !timed_to_reference && (settle == 4'h0) &&
                     (auto_mode || check_pending);
    wire err_hit = check_now && (setup_miss || hold_miss);
    wire auto_up = err_hit && auto_mode && setup_miss && (clock_delay_code != `DITO_CODE_MAX);
    wire auto_dn = err_hit && auto_mode && !setup_miss &&
                   (clock_delay_code != `DITO_CODE_MIN);

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            err_flag <= 1'b0;
            err_type <= 1'b0;
            check_pending <= 1'b1;
            settle <= 4'h0;
        end else begin
            if (err_hit) begin
                err_flag <= 1'b1;
                err_type <= setup_miss;
            end else if (wr_status && reg_wdata[`DITO_STAT_ERR_BIT]) begin
                err_flag <= 1'b0;
            end
            if (enter_manual || cfg_changed) begin
                check_pending <= 1'b1;
            end else if (check_now && !auto_mode) begin
                check_pending <= 1'b0;
            end
            if (auto_up || auto_dn) begin
                settle <= `DITO_SETTLE_CAPTURES;
            end else if (capture_strobe && (settle != 4'h0)) begin
                settle <= settle - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register writes

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            auto_mode <= `DITO_RST_AUTO;
            delay_line_enable <= `DITO_RST_DELAY_EN;
            clock_delay_code <= `DITO_RST_CODE;
            margin <= `DITO_RST_MARGIN;
            timed_to_reference <= `DITO_RST_REFSEL;
            irq_enable <= `DITO_RST_IRQEN;
        end else begin
            if (wr_mode) begin
                auto_mode <= reg_wdata[`DITO_MODE_AUTO_BIT];
            end
            if (wr_delay) begin
                // software write beats an automatic step in the same cycle
                delay_line_enable <= reg_wdata[`DITO_DELAY_EN_BIT];
                clock_delay_code <= wr_code;
            end else if (auto_up) begin
                clock_delay_code <= clock_delay_code + 5'h01;
            end else if (auto_dn) begin
                clock_delay_code <= clock_delay_code - 5'h01;
            end
            if (wr_margin) begin
                margin <= wr_margin_val;
            end
            if (wr_refsel) begin
                timed_to_reference <= reg_wdata[`DITO_REFSEL_BIT];
            end
            if (wr_irqen) begin
                irq_enable <= reg_wdata[`DITO_IRQEN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register reads, data valid only in the cycle after the strobe

    reg [`DITO_DATA_W-1:0] next_rdata;

    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `DITO_OFS_MODE: begin
                next_rdata[`DITO_MODE_AUTO_BIT] = auto_mode;
            end
            `DITO_OFS_DELAY: begin
                next_rdata[`DITO_DELAY_CODE_MSB:0] = clock_delay_code;
                next_rdata[`DITO_DELAY_EN_BIT] = delay_line_enable;
            end
            `DITO_OFS_MARGIN: begin
                next_rdata[`DITO_MARGIN_MSB:0] = margin;
            end
            `DITO_OFS_REFSEL: begin
                next_rdata[`DITO_REFSEL_BIT] = timed_to_reference;
            end
            `DITO_OFS_IRQEN: begin
                next_rdata[`DITO_IRQEN_BIT] = irq_enable;
            end
            `DITO_OFS_STATUS: begin
                next_rdata[`DITO_STAT_ERR_BIT] = err_flag;
                next_rdata[`DITO_STAT_TYPE_BIT] = err_type;
                next_rdata[`DITO_STAT_SYNC_BIT] = sync_sampled;
                next_rdata[`DITO_STAT_PEND_BIT] = check_pending;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // open-drain interrupt: pin only ever pulled low

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_n_out <= 1'b0;
            irq_n_oe <= 1'b0;
        end else begin
            irq_n_out <= 1'b0;
            irq_n_oe <= err_flag && irq_enable;
        end
    end

endmodule // dito_top

// File: test/dito_src_model.sv
// data source model: launches a new word on each forwarded clock rise
`timescale 1ns/1ps

module dito_src_model (
    input wire forwarded_data_clock,
    input wire reset_n,
    output logic [15:0] data_pin
);
    initial data_pin = 16'h0000;
    // words change in every bit set in 16'hA5C3 so any margin capture crossing a launch differs
    always @(posedge forwarded_data_clock or negedge reset_n) begin
        if (!reset_n) begin
            data_pin <= 16'h0000;
        end else begin
            data_pin <= ~data_pin ^ 16'h5A3C;
        end
    end
endmodule // dito_src_model

// File: test/dito_top_sva.sv
// checker of the timing optimizer ports
`timescale 1ns/1ps
`include "dito_regs.vh"

module dito_top_sva (
    input wire clock,
    input wire reset_n,
    input wire [`DITO_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [`DITO_DATA_W-1:0] reg_rdata,
    input wire sync_pin,
    input wire [`DITO_PORT_W-1:0] captured_data,
    input wire captured_valid,
    input wire sync_sampled,
    input wire irq_n_out,
    input wire irq_n_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_lone_read;
        reg_rd ##1 !reg_rd;
    endsequence
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    AST_RD_ONE: assert property (s_lone_read |=> reg_rdata == 8'h00)
        else $error("read data stood too long");
    AST_IRQ_LOW: assert property (irq_n_out == 1'b0)
        else $error("interrupt pin drives high");
    AST_VALID_PERIOD: assert property (captured_valid |-> ##12 captured_valid)
        else $error("capture period not 12");
    AST_VALID_GAP: assert property (captured_valid |=> !captured_valid [*8])
        else $error("extra capture pulse");
    AST_CAPT_HOLD: assert property (!captured_valid |-> $stable(captured_data))
        else $error("captured word moved without capture");
    AST_SYNC: assert property (sync_sampled == $past(sync_pin, 2))
        else $error("sync not two-stage sampled");
    AST_OE_HOLD: assert property ($fell(irq_n_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt dropped without write");
    AST_OE_CAUSE: assert property ($rose(irq_n_oe) |->
        $past(captured_valid) || $past(captured_valid, 2) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt rose without cause");
endmodule // dito_top_sva

bind dito_top dito_top_sva chk_u (.clock(clock), .reset_n(reset_n), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin(sync_pin),
    .captured_data(captured_data), .captured_valid(captured_valid),
    .sync_sampled(sync_sampled), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// File: test/dito_top_tb_top.sv
// register-level tests of the timing optimizer against a data source model
`timescale 1ns/1ps

module dito_top_tb_top;
    logic clock = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, sync_pin = 0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [15:0] data_pin, captured_data;
    logic fdc, captured_valid, sync_sampled, irq_n_out, irq_n_oe;
    int mismatches = 0, cmp_count = 0, p1, p2;
    dito_top dut_u (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .data_pin(data_pin), .sync_pin(sync_pin), .forwarded_data_clock(fdc),
        .captured_data(captured_data), .captured_valid(captured_valid),
        .sync_sampled(sync_sampled), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    dito_src_model src_u (.forwarded_data_clock(fdc), .reset_n(reset_n), .data_pin(data_pin));
    initial begin
        forever #2 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rc(input logic [5:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, exp);
    endtask
    task caps(input int n);
        repeat (n * 12) @(posedge clock);
    endtask
    // cycles from a capture pulse to the next forwarded clock rise
    task ph(output int n);
        logic prev;
        n = 0;
        @(posedge clock);
        while (captured_valid !== 1'b1 && n < 24) begin
            @(posedge clock);
            n++;
        end
        n = 0;
        prev = fdc;
        while (n < 24) begin
            @(posedge clock);
            n++;
            if (fdc === 1'b1 && prev === 1'b0) break;
            prev = fdc;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #200000 mismatches++;
        wrap_up();
    end
    // sync edges only ever land just after a converter clock edge
    always @(posedge clock) sync_pin <= (cmp_count % 3) == 1;
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        for (int a = 3; a < 8; a++) rc(a[5:0], 8'h00, 8'hFF);
        wr(6'h3F, 8'hFF);
        rc(6'h3F, 8'h00, 8'hFF);
        rc(6'h03, 8'h00, 8'hFF);
        wr(6'h04, 8'h83);
        caps(4);
        ph(p1);
        wr(6'h04, 8'h88);
        caps(4);
        ph(p2);
        chk(8'((p2 - p1 + 12) % 12), 8'h05);
        rc(6'h04, 8'h88, 8'hFF);
        rc(6'h19, 8'h00, 8'h01);
        wr(6'h05, 8'h06);
        caps(2);
        rc(6'h19, 8'h01, 8'h01);
        wr(6'h07, 8'h01);
        caps(1);
        chk({7'h00, irq_n_oe}, 8'h01);
        caps(3);
        rc(6'h19, 8'h01, 8'h01);
        wr(6'h19, 8'h01);
        caps(3);
        rc(6'h19, 8'h00, 8'h01);
        chk({7'h00, irq_n_oe}, 8'h00);
        wr(6'h05, 8'h07);
        caps(2);
        rc(6'h19, 8'h01, 8'h01);
        wr(6'h19, 8'h01);
        wr(6'h04, 8'h89);
        caps(2);
        rc(6'h19, 8'h01, 8'h01);
        wr(6'h06, 8'h01);
        wr(6'h19, 8'h01);
        wr(6'h05, 8'h06);
        caps(3);
        rc(6'h19, 8'h00, 8'h01);
        wr(6'h05, 8'h04);
        wr(6'h06, 8'h00);
        wr(6'h03, 8'h80);
        rc(6'h03, 8'h80, 8'h80);
        repeat (3000) @(posedge clock);
        wr(6'h19, 8'h01);
        caps(10);
        rc(6'h19, 8'h00, 8'h01);
        wr(6'h06, 8'h01);
        wr(6'h05, 8'h07);
        wr(6'h19, 8'h01);
        wr(6'h03, 8'h00);
        wr(6'h06, 8'h00);
        caps(2);
        rc(6'h19, 8'h01, 8'h01);
        wrap_up();
    end
endmodule // dito_top_tb_top
